// file: rtl/fws_pkg.sv
// Package with register map, field layout and reset values for the flash wait-state block
`default_nettype none
package fws_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  OFS_CFG     = 4'h0;
  localparam logic [3:0]  OFS_SPEED   = 4'h4;
  localparam logic [3:0]  OFS_STATUS  = 4'h8;

  // Timing configuration layout
  localparam int          EXEC_LSB    = 6;
  localparam int          READ_LSB    = 4;
  localparam int          WRT_LSB     = 0;
  localparam int          WAIT_W      = 2;
  localparam int          WRT_W       = 4;
  localparam logic [7:0]  CFG_RESET   = 8'h00;

  // Speed select: cycles per instruction is code plus one
  localparam int          SPEED_W     = 3;
  localparam logic [2:0]  SPEED_RESET = 3'h0;

  // Status layout: effective exec cycles, read cycles, table read busy
  localparam int          ST_EXEC_LSB = 0;
  localparam int          ST_READ_LSB = 4;
  localparam int          ST_BUSY_BIT = 8;

  // Counter width, enough for the largest stretch of eight cycles
  localparam int          CNT_W       = 4;
  localparam logic [3:0]  CNT_ONE     = 4'h1;

  // Table read sequencer states
  typedef enum logic [0:0]
  {
    FWS_TR_IDLE = 1'b0,
    FWS_TR_BUSY = 1'b1
  } fws_tread_e;
endpackage
`default_nettype wire

// file: rtl/fws_pace.sv
// Cycle pacer: pulses once every len cycles while run is high
`timescale 1ns/1ps
`default_nettype none
module fws_pace #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Pacing control
  input  wire logic         run,
  input  wire logic [W-1:0] len,
  output logic              tick
);
  logic [W-1:0] count;
  logic [W-1:0] count_inc;

  // Greater-or-equal compare so a shrinking len never strands the count
  assign count_inc = count + {{(W-1){1'b0}}, 1'b1};
  assign tick      = run && (count_inc >= len);

  // Restart from zero whenever pacing stops or a period ends
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (!run || tick)
      count <= '0;
    else
      count <= count_inc;
  end
endmodule
`default_nettype wire

// file: rtl/fws_top.sv
// Flash wait-state configuration, execution pacing and table-read timing
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fws_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Avalon-MM register slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Instruction execution from flash
  input  wire logic        exec_active,
  output logic             exec_step,
  // Table reads of flash
  input  wire logic        tread_start,
  output logic             tread_busy,
  output logic             tread_done,
  // Stored write timing for the flash writer
  output logic [3:0]       flash_write_timing_field
);
  logic [7:0]                       flash_timing_config;
  logic [fws_pkg::SPEED_W-1:0]      speed_select_register;
  logic                             ack;
  logic [fws_pkg::WAIT_W-1:0]       flash_exec_wait_field;
  logic [fws_pkg::WAIT_W-1:0]       flash_read_wait_field;
  logic [fws_pkg::CNT_W-1:0]        speed_cycles;
  logic [fws_pkg::CNT_W-1:0]        wait_cycles;
  logic [fws_pkg::CNT_W-1:0]        exec_cycles;
  logic [fws_pkg::CNT_W-1:0]        read_cycles;
  logic [fws_pkg::CNT_W-1:0]        tread_len;
  fws_pkg::fws_tread_e              tr_state;
  logic                             tread_tick;
  logic                             acc;
  logic [31:0]                      next_readdata;

  // Field extraction
  assign flash_exec_wait_field    = flash_timing_config[fws_pkg::EXEC_LSB +: fws_pkg::WAIT_W];
  assign flash_read_wait_field    = flash_timing_config[fws_pkg::READ_LSB +: fws_pkg::WAIT_W];
  assign flash_write_timing_field = flash_timing_config[fws_pkg::WRT_LSB +: fws_pkg::WRT_W];

  // Codes map to code plus one cycles
  assign wait_cycles  = {{(fws_pkg::CNT_W-fws_pkg::WAIT_W){1'b0}}, flash_exec_wait_field}
                        + fws_pkg::CNT_ONE;
  assign read_cycles  = {{(fws_pkg::CNT_W-fws_pkg::WAIT_W){1'b0}}, flash_read_wait_field}
                        + fws_pkg::CNT_ONE;
  assign speed_cycles = {{(fws_pkg::CNT_W-fws_pkg::SPEED_W){1'b0}}, speed_select_register}
                        + fws_pkg::CNT_ONE;

  // Slower of the two rates means more cycles per instruction
  assign exec_cycles  = (wait_cycles > speed_cycles) ? wait_cycles : speed_cycles;

  // One wait state per access keeps read data registered
  assign waitrequest = (read || write) && !ack;
  assign acc         = (read || write) && ack;

  // Access handshake phase
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= (read || write) && !ack;
  end

  // Register writes take effect only on the accepting edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_timing_config   <= fws_pkg::CFG_RESET;
      speed_select_register <= fws_pkg::SPEED_RESET;
    end
    else if (acc && write && byteenable[0])
    begin
      if (address == fws_pkg::OFS_CFG)
        flash_timing_config <= writedata[7:0];
      else if (address == fws_pkg::OFS_SPEED)
        speed_select_register <= writedata[fws_pkg::SPEED_W-1:0];
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (address)
      fws_pkg::OFS_CFG:
        next_readdata[7:0] = flash_timing_config;
      fws_pkg::OFS_SPEED:
        next_readdata[fws_pkg::SPEED_W-1:0] = speed_select_register;
      fws_pkg::OFS_STATUS:
      begin
        next_readdata[fws_pkg::ST_EXEC_LSB +: fws_pkg::CNT_W] = exec_cycles;
        next_readdata[fws_pkg::ST_READ_LSB +: fws_pkg::CNT_W] = read_cycles;
        next_readdata[fws_pkg::ST_BUSY_BIT]                   = tread_busy;
      end
      default:
        next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle, stands at the accepting edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      readdata <= 32'h0000_0000;
    else if (read && !ack)
      readdata <= next_readdata;
  end

  // Execution pacer: one instruction every exec_cycles while fetching from flash
  fws_pace #(
    .W (fws_pkg::CNT_W)
  ) u_exec_pace (
    .clock (clock),
    .rst_n (rst_n),
    .run   (exec_active),
    .len   (exec_cycles),
    .tick  (exec_step)
  );

  // Table read sequencer; length latched at start so a config write mid-read is harmless
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tr_state  <= fws_pkg::FWS_TR_IDLE;
      tread_len <= fws_pkg::CNT_ONE;
    end
    else
    begin
      case (tr_state)
        fws_pkg::FWS_TR_IDLE:
          if (tread_start)
          begin
            tr_state  <= fws_pkg::FWS_TR_BUSY;
            tread_len <= read_cycles;
          end
        fws_pkg::FWS_TR_BUSY:
          if (tread_tick)
            tr_state <= fws_pkg::FWS_TR_IDLE;
        default:
          tr_state <= fws_pkg::FWS_TR_IDLE;
      endcase
    end
  end

  assign tread_busy = (tr_state == fws_pkg::FWS_TR_BUSY);
  assign tread_done = tread_tick;

  // Table read pacer: busy for exactly tread_len cycles
  fws_pace #(
    .W (fws_pkg::CNT_W)
  ) u_tread_pace (
    .clock (clock),
    .rst_n (rst_n),
    .run   (tread_busy),
    .len   (tread_len),
    .tick  (tread_tick)
  );

  // Helper counters watched only by the checks below
  logic [fws_pkg::CNT_W-1:0] since_step;
  logic [fws_pkg::CNT_W-1:0] busy_count;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      since_step <= '0;
    else if (!exec_active || exec_step)
      since_step <= '0;
    else
      since_step <= since_step + fws_pkg::CNT_ONE;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      busy_count <= '0;
    else if (!tread_busy)
      busy_count <= '0;
    else
      busy_count <= busy_count + fws_pkg::CNT_ONE;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Bus handshake: one wait cycle then acceptance
  sequence req_rise_s;
    (read || write) && !$past(read || write);
  endsequence
  sequence one_wait_s;
    waitrequest ##1 !waitrequest;
  endsequence

  bus_wait_a: assert property (req_rise_s |-> one_wait_s)
    else $error("access not accepted after one wait cycle");

  // Flash instruction never issued faster than the wait field allows
  exec_floor_a: assert property (exec_step && exec_active && $stable(exec_cycles)
                                 |-> since_step + fws_pkg::CNT_ONE >= wait_cycles)
    else $error("flash instruction issued too early");

  exec_slower_a: assert property (exec_cycles >= speed_cycles
                                  && exec_cycles >= wait_cycles
                                  && (exec_cycles == speed_cycles
                                      || exec_cycles == wait_cycles))
    else $error("execution rate is not the slower one");

  exec_code11_a: assert property (flash_exec_wait_field == 2'h3 && exec_active
                                  && $stable(exec_cycles) && exec_step
                                  |=> (!exec_step) [*3])
    else $error("wait code 11 did not give four cycles");

  tread_len_a: assert property (tread_done |-> busy_count + fws_pkg::CNT_ONE == tread_len)
    else $error("table read length wrong");

  tread_one_a: assert property (!tread_busy && tread_start && flash_read_wait_field == 2'h0
                                |=> tread_done)
    else $error("read wait 00 not one cycle");

  tread_two_a: assert property (!tread_busy && tread_start && flash_read_wait_field == 2'h1
                                |=> !tread_done ##1 tread_done)
    else $error("read wait 01 not two cycles");

  cfg_readback_a: assert property (acc && write && byteenable[0]
                                   && address == fws_pkg::OFS_CFG
                                   |=> flash_write_timing_field == $past(writedata[3:0]))
    else $error("write timing field not stored");
endmodule
`default_nettype wire

// file: dv/fws_flash_model.sv
// Flash side model: issues fetches and table reads, times the answers
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model (
  // Clock
  input  wire logic clock,
  // Pacing from the block
  input  wire logic exec_step,
  input  wire logic tread_busy,
  input  wire logic tread_done,
  // Requests to the block
  output logic      exec_active,
  output logic      tread_start
);
  initial
  begin
    exec_active = 1'b0;
    tread_start = 1'b0;
  end

  // Fetch until two steps; 99 marks a hang
  task automatic fetch(output int first, output int gap);
    int k;
    first = 99;
    gap = 99;
    @(posedge clock);
    exec_active <= 1'b1;
    for (k = 1; k < 20 && gap == 99; k++)
    begin
      @(posedge clock);
      if (exec_step === 1'b1)
      begin
        if (first == 99)
          first = k;
        else
          gap = k - first;
      end
    end
    // Low for a cycle so pacing restarts
    exec_active <= 1'b0;
  endtask

  // Start held into the first busy cycle, which must be ignored
  task automatic tread(output int busy, output int done_at);
    int k;
    busy = 0;
    done_at = 0;
    @(posedge clock);
    tread_start <= 1'b1;
    for (k = 0; k < 12; k++)
    begin
      @(posedge clock);
      if (k == 1)
        tread_start <= 1'b0;
      if (tread_busy === 1'b1)
        busy++;
      if (tread_done === 1'b1)
        done_at = busy;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/fws_top_test.sv
// Self-checking bench for the flash wait-state block
`timescale 1ns/1ps
`default_nettype none
module fws_top_test;
  logic        clock;
  logic        rst_n;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        exec_active;
  logic        exec_step;
  logic        tread_start;
  logic        tread_busy;
  logic        tread_done;
  logic [3:0]  flash_write_timing_field;
  int          fail_count;
  int          samples_checked;
  int          i;
  int          f;
  int          g;

  fws_top fws_top_inst (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .exec_active(exec_active), .exec_step(exec_step),
    .tread_start(tread_start), .tread_busy(tread_busy), .tread_done(tread_done),
    .flash_write_timing_field(flash_write_timing_field));
  fws_flash_model fws_flash_model_inst (.clock(clock), .exec_step(exec_step),
    .tread_busy(tread_busy), .tread_done(tread_done), .exec_active(exec_active),
    .tread_start(tread_start));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
      $display("Error %s expected %h seen %h", name, exp, seen);
    if (seen !== exp)
      fail_count++;
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, logic [3:0] be,
    output logic [31:0] q);
    int k;
    @(posedge clock);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clock);
      if (waitrequest === 1'b0)
        break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k == 20)
    begin
      fail_count++;
      end_of_test();
    end
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d, logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd(string name, logic [3:0] a, logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(name, q, exp);
  endtask

  initial
  begin
    rst_n = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    // Reset state and an unmapped place
    rd("cfg", fws_pkg::OFS_CFG, 32'h00);
    rd("speed", fws_pkg::OFS_SPEED, 32'h0);
    rd("status", fws_pkg::OFS_STATUS, 32'h11);
    rd("hole", 4'hc, 32'h0);
    // All fields set; upper write bits must not stick
    wr(fws_pkg::OFS_CFG, 32'hffff_ffa5, 4'hf);
    rd("cfg", fws_pkg::OFS_CFG, 32'ha5);
    check("wrt", {28'h0, flash_write_timing_field}, 32'h5);
    rd("status", fws_pkg::OFS_STATUS, 32'h33);
    // Write with low lane disabled is dropped
    wr(fws_pkg::OFS_CFG, 32'h3c, 4'he);
    rd("cfg", fws_pkg::OFS_CFG, 32'ha5);
    // Every band code; 20 MHz sits in the lowest band anyway
    for (i = 0; i < 4; i++)
    begin
      wr(fws_pkg::OFS_CFG, 32'(i << fws_pkg::EXEC_LSB), 4'hf);
      fws_flash_model_inst.fetch(f, g);
      check("first", f, i + 1);
      check("gap", g, i + 1);
    end
    // Speed select against a three-cycle wait: slower wins
    wr(fws_pkg::OFS_CFG, 32'h80, 4'hf);
    for (i = 0; i < 8; i++)
    begin
      wr(fws_pkg::OFS_SPEED, 32'(i), 4'hf);
      fws_flash_model_inst.fetch(f, g);
      check("gap", g, (i > 2) ? i + 1 : 3);
    end
    wr(fws_pkg::OFS_SPEED, 32'h0, 4'hf);
    // Table read length per read code, set for the fastest core speed
    for (i = 0; i < 4; i++)
    begin
      wr(fws_pkg::OFS_CFG, 32'(i << fws_pkg::READ_LSB), 4'hf);
      fws_flash_model_inst.tread(f, g);
      check("busy", f, i + 1);
      check("done", g, i + 1);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
